//--- core/pmicif_top.sv
`include "pmicif_map.svh"
module pmicif_top #(
	parameter int NUM_BUCK = 4,
	parameter int NUM_LDO  = 9,
	parameter int NUM_GPIO = 8
) (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RESETN_IN,
	// register port
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [7:0]  REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [7:0]  REG_RDATA_OUT,
	output logic             REG_RVALID_OUT,
	// regulator detectors; buck ones asynchronous levels, LDO events used without synchroniser
	input  wire logic [3:0]  BUCK_OV_IN,
	input  wire logic [3:0]  BUCK_UV_IN,
	input  wire logic [3:0]  BUCK_EN_IN,
	input  wire logic [8:0]  LDO_EVENT_IN,
	// pins and their transition selects
	input  wire logic [7:0]  GPIO_PIN_IN,
	input  wire logic [15:0] PIN_TRANSITION_SELECT_IN,
	// pending flags of neighbouring flag registers
	input  wire logic [2:0]  BATT_TEMP_FLAGS_IN,
	input  wire logic [5:0]  POWER_SWITCH_FLAGS_IN,
	input  wire logic        RTC_PENDING_IN,
	// summary and interrupt
	output logic      [7:0]  TOP_STATUS_OUT,
	output logic             IRQ_N_OUT
);

	////////////////////////////////////////////////////////////////////////////////
	// register layout is fixed at eight bits, so the counts cannot move
	generate
		if (NUM_BUCK != 4 || NUM_LDO != 9 || NUM_GPIO != 8)
		begin : g_bad
			$error("pmicif_top: unsupported resource counts");
		end
	endgenerate

	pmicif_pkg::pmicif_req_t  req;
	pmicif_pkg::pmicif_pend_t pend;

	logic [7:0] buck_ff, nxt_buck, buck_set;
	logic [7:0] ldo_lo_ff, nxt_ldo_lo;
	logic       ldo8_ff, nxt_ldo8;
	logic [7:0] gpio_ff, nxt_gpio, gpio_set;
	logic [7:0] pin_prev_ff, nxt_pin_prev;
	logic [7:0] top_msk_ff, nxt_top_msk;
	logic [7:0] batt_msk_ff, nxt_batt_msk;
	logic [7:0] psw_msk_ff, nxt_psw_msk;
	logic [7:0] buck_msk_ff, nxt_buck_msk;
	logic [7:0] ldo_msk_ff, nxt_ldo_msk;
	logic       ldo8_msk_ff, nxt_ldo8_msk;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       rvalid_ff, nxt_rvalid;
	logic [7:0] status_ff, nxt_status;
	logic       irq_n_ff, nxt_irq_n;
	logic [19:0] sync_lvl;
	logic [3:0] ov_s, uv_s, en_s;
	logic [7:0] pin_s;
	logic       any_irq;

	assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

	// true when a read or write targets the given offset
	function automatic logic hit(input pmicif_pkg::pmicif_req_t r, input logic [7:0] a,
		input logic is_rd);
		hit = (r.addr == a) && (is_rd ? r.rd : r.wr);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// buck detector and pin inputs come from other domains
	pmicif_sync #(
		.WIDTH     (20)
	) u_sync (
		.clk_in    (CLK_IN),
		.resetn_in (RESETN_IN),
		.async_in  ({GPIO_PIN_IN, BUCK_EN_IN, BUCK_UV_IN, BUCK_OV_IN}),
		.level_out (sync_lvl)
	);

	assign ov_s  = sync_lvl[3:0];
	assign uv_s  = sync_lvl[7:4];
	assign en_s  = sync_lvl[11:8];
	assign pin_s = sync_lvl[19:12];

	////////////////////////////////////////////////////////////////////////////////
	// sticky flags; a set in the read cycle beats the clear so no event is lost
	always_comb
	begin
		buck_set = '0;
		gpio_set = '0;
		for (int i = 0; i < NUM_BUCK; i++)
		begin
			buck_set[7 - 2 * i] = ov_s[i];
			buck_set[6 - 2 * i] = uv_s[i] & en_s[i];
		end
		for (int i = 0; i < NUM_GPIO; i++)
		begin
			case (PIN_TRANSITION_SELECT_IN[2 * i +: 2])
				`PMICIF_EDGE_RISE: gpio_set[i] = pin_s[i] & ~pin_prev_ff[i];
				`PMICIF_EDGE_FALL: gpio_set[i] = ~pin_s[i] & pin_prev_ff[i];
				`PMICIF_EDGE_BOTH: gpio_set[i] = pin_s[i] ^ pin_prev_ff[i];
				default:           gpio_set[i] = 1'b0;
			endcase
		end
		nxt_pin_prev = pin_s;
		nxt_buck     = (hit(req, `PMICIF_ADDR_BUCK_FLAGS, 1'b1) ? 8'h00 : buck_ff)
			| buck_set;
		nxt_ldo_lo   = (hit(req, `PMICIF_ADDR_LDO_LO_FLAGS, 1'b1) ? 8'h00 : ldo_lo_ff)
			| LDO_EVENT_IN[7:0];
		nxt_ldo8     = (hit(req, `PMICIF_ADDR_LDO_HI_FLAGS, 1'b1) ? 1'b0 : ldo8_ff)
			| LDO_EVENT_IN[8];
		// a select of zero also wipes a flag already standing on that pin
		for (int i = 0; i < NUM_GPIO; i++)
		begin
			if (PIN_TRANSITION_SELECT_IN[2 * i +: 2] == `PMICIF_EDGE_OFF)
				gpio_set[i] = 1'b0;
		end
		nxt_gpio     = (hit(req, `PMICIF_ADDR_GPIO_FLAGS, 1'b1) ? 8'h00 : gpio_ff)
			| gpio_set;
		for (int i = 0; i < NUM_GPIO; i++)
		begin
			if (PIN_TRANSITION_SELECT_IN[2 * i +: 2] == `PMICIF_EDGE_OFF)
				nxt_gpio[i] = 1'b0;
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			buck_ff     <= `PMICIF_RST_FLAGS;
			ldo_lo_ff   <= `PMICIF_RST_FLAGS;
			ldo8_ff     <= 1'b0;
			gpio_ff     <= `PMICIF_RST_FLAGS;
			pin_prev_ff <= 8'h00;
		end
		else
		begin
			buck_ff     <= nxt_buck;
			ldo_lo_ff   <= nxt_ldo_lo;
			ldo8_ff     <= nxt_ldo8;
			gpio_ff     <= nxt_gpio;
			pin_prev_ff <= nxt_pin_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// mask registers; reserved bits are dropped on write, so they read zero
	always_comb
	begin
		nxt_top_msk  = top_msk_ff;
		nxt_batt_msk = batt_msk_ff;
		nxt_psw_msk  = psw_msk_ff;
		nxt_buck_msk = buck_msk_ff;
		nxt_ldo_msk  = ldo_msk_ff;
		nxt_ldo8_msk = ldo8_msk_ff;
		if (hit(req, `PMICIF_ADDR_TOP_MASKS, 1'b0))
			nxt_top_msk = req.wdata & `PMICIF_WMASK_TOP_MASKS;
		if (hit(req, `PMICIF_ADDR_BATT_MASKS, 1'b0))
			nxt_batt_msk = req.wdata & `PMICIF_WMASK_BATT_MASKS;
		if (hit(req, `PMICIF_ADDR_PSW_MASKS, 1'b0))
			nxt_psw_msk = req.wdata & `PMICIF_WMASK_PSW_MASKS;
		if (hit(req, `PMICIF_ADDR_BUCK_MASKS, 1'b0))
			nxt_buck_msk = req.wdata;
		if (hit(req, `PMICIF_ADDR_LDO_LO_MASKS, 1'b0))
			nxt_ldo_msk = req.wdata;
		if (hit(req, `PMICIF_ADDR_LDO_HI_MASKS, 1'b0))
			nxt_ldo8_msk = req.wdata[0];
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			top_msk_ff  <= `PMICIF_RST_TOP_MASKS;
			batt_msk_ff <= `PMICIF_RST_BATT_MASKS;
			psw_msk_ff  <= `PMICIF_RST_PSW_MASKS;
			buck_msk_ff <= `PMICIF_RST_SRC_MASKS;
			ldo_msk_ff  <= `PMICIF_RST_SRC_MASKS;
			ldo8_msk_ff <= `PMICIF_RST_LDO8_MASK;
		end
		else
		begin
			top_msk_ff  <= nxt_top_msk;
			batt_msk_ff <= nxt_batt_msk;
			psw_msk_ff  <= nxt_psw_msk;
			buck_msk_ff <= nxt_buck_msk;
			ldo_msk_ff  <= nxt_ldo_msk;
			ldo8_msk_ff <= nxt_ldo8_msk;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// group summaries; a source mask of one keeps the flag but hides it
	always_comb
	begin
		pend.buck = |(buck_ff & ~buck_msk_ff);
		pend.ldo  = |(ldo_lo_ff & ~ldo_msk_ff) | (ldo8_ff & ~ldo8_msk_ff);
		pend.gpio = |gpio_ff;
		pend.glbl = |(BATT_TEMP_FLAGS_IN & ~batt_msk_ff[2:0]);
		pend.psw  = |(POWER_SWITCH_FLAGS_IN & ~psw_msk_ff[5:0]);
		pend.rtc  = RTC_PENDING_IN;
		any_irq   = (pend.glbl & ~top_msk_ff[`PMICIF_BIT_GLBL])
			| (pend.buck & ~top_msk_ff[`PMICIF_BIT_BUCK])
			| (pend.ldo  & ~top_msk_ff[`PMICIF_BIT_LDO])
			| (pend.gpio & ~top_msk_ff[`PMICIF_BIT_GPIO])
			| (pend.rtc  & ~top_msk_ff[`PMICIF_BIT_RTC])
			| (pend.psw  & ~top_msk_ff[`PMICIF_BIT_PSW]);
		nxt_status = 8'h00;
		nxt_status[`PMICIF_BIT_GLBL]   = pend.glbl;
		nxt_status[`PMICIF_BIT_BUCK]   = pend.buck;
		nxt_status[`PMICIF_BIT_LDO]    = pend.ldo;
		nxt_status[`PMICIF_BIT_GPIO]   = pend.gpio;
		nxt_status[`PMICIF_BIT_RTC]    = pend.rtc;
		nxt_status[`PMICIF_BIT_PSW]    = pend.psw;
		nxt_status[`PMICIF_BIT_MASTER] = any_irq & ~top_msk_ff[`PMICIF_BIT_MASTER];
		nxt_irq_n  = ~(any_irq & ~top_msk_ff[`PMICIF_BIT_MASTER]);
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			status_ff <= 8'h00;
			irq_n_ff  <= 1'b1;
		end
		else
		begin
			status_ff <= nxt_status;
			irq_n_ff  <= nxt_irq_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data is registered: the value before the clear, one cycle later
	always_comb
	begin
		nxt_rdata  = rdata_ff;
		nxt_rvalid = req.rd;
		if (req.rd)
		begin
			case (req.addr)
				`PMICIF_ADDR_BUCK_FLAGS:   nxt_rdata = buck_ff;
				`PMICIF_ADDR_LDO_LO_FLAGS: nxt_rdata = ldo_lo_ff;
				`PMICIF_ADDR_LDO_HI_FLAGS: nxt_rdata = {7'h00, ldo8_ff};
				`PMICIF_ADDR_GPIO_FLAGS:   nxt_rdata = gpio_ff;
				`PMICIF_ADDR_TOP_MASKS:    nxt_rdata = top_msk_ff;
				`PMICIF_ADDR_BATT_MASKS:   nxt_rdata = batt_msk_ff;
				`PMICIF_ADDR_PSW_MASKS:    nxt_rdata = psw_msk_ff;
				`PMICIF_ADDR_BUCK_MASKS:   nxt_rdata = buck_msk_ff;
				`PMICIF_ADDR_LDO_LO_MASKS: nxt_rdata = ldo_msk_ff;
				`PMICIF_ADDR_LDO_HI_MASKS: nxt_rdata = {7'h00, ldo8_msk_ff};
				default:                   nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
		end
	end

	assign REG_RDATA_OUT  = rdata_ff;
	assign REG_RVALID_OUT = rvalid_ff;
	assign TOP_STATUS_OUT = status_ff;
	assign IRQ_N_OUT      = irq_n_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_ov_latch;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		ov_s[0] |=> buck_ff[7];
	endproperty
	a_ov_latch: assert property (p_ov_latch) else $error("overvoltage not latched");

	property p_uv_disabled;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(!en_s[3] && !buck_ff[0]) |=> !buck_ff[0];
	endproperty
	a_uv_disabled: assert property (p_uv_disabled) else $error("uv set while off");

	property p_buck_rc;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(hit(req, `PMICIF_ADDR_BUCK_FLAGS, 1'b1) && buck_set == 8'h00)
			|=> (buck_ff == 8'h00) && (REG_RDATA_OUT == $past(buck_ff)) && REG_RVALID_OUT;
	endproperty
	a_buck_rc: assert property (p_buck_rc) else $error("buck read clear wrong");

	property p_ldo_rec;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		LDO_EVENT_IN[3] |=> ldo_lo_ff[3];
	endproperty
	a_ldo_rec: assert property (p_ldo_rec) else $error("ldo event lost");

	property p_ldo8_resv;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		hit(req, `PMICIF_ADDR_LDO_HI_FLAGS, 1'b1) |=> REG_RDATA_OUT[7:1] == 7'h00;
	endproperty
	a_ldo8_resv: assert property (p_ldo8_resv) else $error("ldo8 reserved nonzero");

	property p_pin_off;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(PIN_TRANSITION_SELECT_IN[1:0] == `PMICIF_EDGE_OFF) |=> !gpio_ff[0];
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("masked pin flag set");

	property p_pin_rc;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(hit(req, `PMICIF_ADDR_GPIO_FLAGS, 1'b1) && gpio_set == 8'h00) |=> gpio_ff == 8'h00;
	endproperty
	a_pin_rc: assert property (p_pin_rc) else $error("pin flag not cleared");

	property p_resv_zero;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		!top_msk_ff[2] && (batt_msk_ff[7:3] == 5'h00) && (psw_msk_ff[7:6] == 2'h0);
	endproperty
	a_resv_zero: assert property (p_resv_zero) else $error("reserved mask bit set");

	property p_master;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		top_msk_ff[`PMICIF_BIT_MASTER] |=> IRQ_N_OUT;
	endproperty
	a_master: assert property (p_master) else $error("irq despite master mask");

	property p_sum_buck;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		(|(buck_ff & ~buck_msk_ff)) |=> TOP_STATUS_OUT[`PMICIF_BIT_BUCK];
	endproperty
	a_sum_buck: assert property (p_sum_buck) else $error("buck summary missing");

	property p_irq_cause;
		@(posedge CLK_IN) disable iff (!RESETN_IN)
		$fell(IRQ_N_OUT) |-> $past(any_irq) && !$past(top_msk_ff[`PMICIF_BIT_MASTER]);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");

	c_irq:   cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $fell(IRQ_N_OUT));
	c_buck:  cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
		buck_ff[6] && hit(req, `PMICIF_ADDR_BUCK_FLAGS, 1'b1));
	c_pin:   cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) gpio_set[0]);
	c_clear: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) $rose(IRQ_N_OUT));

endmodule

//--- include/pmicif_map.svh
`ifndef PMICIF_MAP_SVH
`define PMICIF_MAP_SVH

// register offsets
`define PMICIF_ADDR_BUCK_FLAGS   8'h03
`define PMICIF_ADDR_LDO_LO_FLAGS 8'h04
`define PMICIF_ADDR_LDO_HI_FLAGS 8'h05
`define PMICIF_ADDR_GPIO_FLAGS   8'h06
`define PMICIF_ADDR_TOP_MASKS    8'h07
`define PMICIF_ADDR_BATT_MASKS   8'h08
`define PMICIF_ADDR_PSW_MASKS    8'h09
`define PMICIF_ADDR_BUCK_MASKS   8'h0A
`define PMICIF_ADDR_LDO_LO_MASKS 8'h0B
`define PMICIF_ADDR_LDO_HI_MASKS 8'h0C

// reset values and writable-bit masks
`define PMICIF_RST_FLAGS         8'h00
`define PMICIF_RST_TOP_MASKS     8'hFB
`define PMICIF_WMASK_TOP_MASKS   8'hFB
`define PMICIF_RST_BATT_MASKS    8'h07
`define PMICIF_WMASK_BATT_MASKS  8'h07
`define PMICIF_RST_PSW_MASKS     8'h3F
`define PMICIF_WMASK_PSW_MASKS   8'h3F
`define PMICIF_RST_SRC_MASKS     8'hFF
`define PMICIF_RST_LDO8_MASK     1'h1

// top-level mask and summary bit positions
`define PMICIF_BIT_GLBL          7
`define PMICIF_BIT_BUCK          6
`define PMICIF_BIT_LDO           5
`define PMICIF_BIT_GPIO          4
`define PMICIF_BIT_RTC           3
`define PMICIF_BIT_PSW           1
`define PMICIF_BIT_MASTER        0

// per-pin transition select codes
`define PMICIF_EDGE_OFF          2'h0
`define PMICIF_EDGE_RISE         2'h1
`define PMICIF_EDGE_FALL         2'h2
`define PMICIF_EDGE_BOTH         2'h3

`endif

//--- include/pmicif_pkg.sv
package pmicif_pkg;

	// one register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pmicif_req_t;

	// per-group pending summary
	typedef struct packed {
		logic glbl;
		logic buck;
		logic ldo;
		logic gpio;
		logic rtc;
		logic psw;
	} pmicif_pend_t;

endpackage

//--- core/pmicif_sync.sv
module pmicif_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             resetn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, q_ff;
	logic [WIDTH-1:0] nxt_s1, nxt_s2, nxt_s3, nxt_q;

	////////////////////////////////////////////////////////////////////////////////
	// three stages; output moves only where stages two and three agree
	always_comb
	begin
		nxt_s1 = async_in;
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
		nxt_q  = (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
	end

	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff  <= '0;
		end
		else
		begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
			q_ff  <= nxt_q;
		end
	end

	assign level_out = q_ff;

endmodule

//--- verif/pmicif_host_model.sv
module pmicif_host_model (
	// clock
	input  wire logic       clk_in,
	// register port towards the device
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle port from time zero, no strobe before reset ends
	initial
	begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end

	////////////////////////////////////////
	// one write: strobe held for exactly one taking edge
	// callers keep reserved bits zero except the drop test
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d; // stale data must not be reused
	endtask

	// one read: the answer is picked up by the bench monitor
	task automatic read_reg(input logic [7:0] a);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
	endtask
endmodule

//--- verif/pmicif_top_test.sv
module pmicif_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk, resetn, wr, rd, rvalid, irq_n, rtc;
	logic [3:0] buck_ov, buck_uv, buck_en;
	logic [8:0] ldo_ev, v;
	logic [7:0] pins, addr, wdata, rdata, status, seed;
	logic [15:0] sel;
	logic [2:0] batt;
	logic [5:0] psw;
	int         num_errors, total_checks;
	logic [7:0] exp_q[$];
	logic [7:0] ra[8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h20};
	logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFB, 8'h07, 8'h3F, 8'h00};

	pmicif_top i_dut (
		.CLK_IN(clk), .RESETN_IN(resetn),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.BUCK_OV_IN(buck_ov), .BUCK_UV_IN(buck_uv), .BUCK_EN_IN(buck_en),
		.LDO_EVENT_IN(ldo_ev), .GPIO_PIN_IN(pins), .PIN_TRANSITION_SELECT_IN(sel),
		.BATT_TEMP_FLAGS_IN(batt), .POWER_SWITCH_FLAGS_IN(psw), .RTC_PENDING_IN(rtc),
		.TOP_STATUS_OUT(status), .IRQ_N_OUT(irq_n)
	);

	pmicif_host_model i_host (
		.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd)
	);

	// 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////
	// shift register for stimulus values
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic chk_reg(input string what, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			num_errors++;
		end
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		total_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
			num_errors++;
		end
	endtask

	task automatic rdx(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.read_reg(a);
	endtask

	task automatic wrx(input logic [7:0] a, input logic [7:0] d);
		i_host.write_reg(a, d);
	endtask

	// covers synchroniser depth plus the registered summary
	task automatic settle;
		repeat (8) @(negedge clk);
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// read answers are compared off the falling edge, oldest note first
	always @(negedge clk)
	begin
		if (rvalid === 1'b1)
			chk_reg("read data", exp_q.pop_front(), rdata);
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("watchdog expired");
		complete_run();
	end

	////////////////////////////////////////
	// main sequence
	initial
	begin
		resetn = 1'b0;
		{buck_ov, buck_uv, buck_en, ldo_ev, pins, sel, batt, psw, rtc} = '0;
		seed = 8'h43;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		chk_bit("irq after reset", 1'b1, irq_n);
		for (int i = 0; i < 8; i++)
			rdx(ra[i], rv[i]);
		wrx(8'h07, 8'hFF);
		wrx(8'h08, 8'hFF);
		wrx(8'h06, 8'hFF);
		rdx(8'h07, 8'hFB);
		rdx(8'h08, 8'h07);
		rdx(8'h06, 8'h00);
		$display("test reset_values done");

		// buck: over-voltage 0, under-voltage 1 enabled, 3 disabled
		@(posedge clk);
		buck_en <= 4'h2;
		buck_ov <= 4'h1;
		buck_uv <= 4'hA;
		repeat (8) @(posedge clk);
		buck_ov <= 4'h0;
		buck_uv <= 4'h0;
		settle();
		chk_bit("buck summary masked", 1'b0, status[6]);
		wrx(8'h0A, 8'h00);
		wrx(8'h07, 8'hBA);
		settle();
		chk_bit("buck summary", 1'b1, status[6]);
		chk_bit("irq buck", 1'b0, irq_n);
		wrx(8'h07, 8'hBB);
		settle();
		chk_bit("irq master", 1'b1, irq_n);
		chk_bit("gated bit master", 1'b0, status[0]);
		wrx(8'h07, 8'h8A);
		rdx(8'h03, 8'h90);
		rdx(8'h03, 8'h00);
		settle();
		chk_bit("irq buck cleared", 1'b1, irq_n);
		$display("test buck_flags done");

		// ldo events recorded while masked, then unmasked
		for (int k = 0; k < 2; k++)
		begin
			seed = lfsr(seed);
			v = {seed[5], seed | 8'h01};
			wrx(8'h0B, 8'hFF);
			wrx(8'h0C, 8'h01);
			@(posedge clk);
			ldo_ev <= v;
			@(posedge clk);
			ldo_ev <= 9'h000;
			settle();
			chk_bit("irq ldo masked", 1'b1, irq_n);
			wrx(8'h0B, 8'h00);
			wrx(8'h0C, 8'h00);
			settle();
			chk_bit("ldo summary", 1'b1, status[5]);
			chk_bit("irq ldo", 1'b0, irq_n);
			rdx(8'h04, v[7:0]);
			rdx(8'h05, {7'h00, v[8]});
			settle();
			chk_bit("irq ldo cleared", 1'b1, irq_n);
		end
		$display("test ldo_flags done");

		// pin i gets select code i mod 4: off, rise, fall, both
		@(posedge clk);
		sel <= 16'hE4E4;
		settle();
		@(posedge clk);
		pins <= 8'hFF;
		settle();
		chk_bit("irq pin", 1'b0, irq_n);
		rdx(8'h06, 8'hAA);
		@(posedge clk);
		pins <= 8'h00;
		settle();
		rdx(8'h06, 8'hCC);
		rdx(8'h06, 8'h00);
		$display("test pin_flags done");

		// global mask hides battery/temperature only
		@(posedge clk);
		batt <= 3'h4;
		wrx(8'h08, 8'h00);
		settle();
		chk_bit("irq batt glbl masked", 1'b1, irq_n);
		wrx(8'h07, 8'h0A);
		settle();
		chk_bit("glbl summary", 1'b1, status[7]);
		chk_bit("irq batt", 1'b0, irq_n);
		wrx(8'h07, 8'h88);
		@(posedge clk);
		batt <= 3'h0;
		psw <= 6'h20;
		wrx(8'h09, 8'h1F);
		settle();
		chk_bit("irq power switch", 1'b0, irq_n);
		wrx(8'h09, 8'h3F);
		settle();
		chk_bit("irq power switch masked", 1'b1, irq_n);
		@(posedge clk);
		psw <= 6'h00;
		rtc <= 1'b1;
		wrx(8'h07, 8'h00);
		settle();
		chk_bit("rtc summary", 1'b1, status[3]);
		chk_bit("irq rtc", 1'b0, irq_n);
		$display("test group_masks done");
		complete_run();
	end
endmodule
